// ### rdrg_pkg.sv
// Constants and types for the ROM decode and RAM guard block
// Function
// RULE_01 - Unrestricted mode lets all RAM be accessed in user and supervisor state
// RULE_02 - Restricted mode limits user-state RAM access to the lowest 512K bytes
// RULE_03 - Restricted mode still lets supervisor cycles reach all 2M of RAM
// RULE_04 - Restricted mode allows I/O cycles only in supervisor state
// RULE_05 - ROM is one 256K region 00800000..0083FFFF read 32 bits wide
// RULE_06 - Socket 0 drives bits 31:24, socket 3 drives bits 7:0
// RULE_07 - Size select of 8K, 16K, 32K or 64K routes matching address lines
// RULE_08 - Smaller ROMs ignore upper address bits so contents repeat
// RULE_09 - ROM cycles get 1, 2, 3 or 5 selectable wait states
// RULE_10 - Integrator picks wait states covering the ROM access time
// RULE_11 - After reset the two low restart long words read from ROM
// RULE_12 - After both restart reads the overlay ends and low memory is RAM
// RULE_13 - Every RAM cycle gets exactly one wait state
// RULE_14 - Refused cycles end with bus error and reach no device
// RULE_15 - ROM-region writes do nothing; overlay counts only reads
package rdrg_pkg;

  localparam logic [31:0] ROM_BASE      = 32'h0080_0000;
  localparam logic [31:0] ROM_TOP       = 32'h0083_ffff;
  localparam logic [31:0] RAM_TOP       = 32'h001f_ffff;
  localparam logic [31:0] RAM_USER_TOP  = 32'h0007_ffff;
  localparam logic [31:0] IO_BASE       = 32'h00ff_0000;
  localparam logic [31:0] IO_TOP        = 32'h00ff_ffff;
  localparam logic [31:0] VEC_ADDR_1    = 32'h0000_0004;

  localparam int          ROM_ADDR_W    = 16;
  localparam logic [2:0]  RAM_WAITS     = 3'h1;
  localparam logic [1:0]  OVL_READS     = 2'h2;

  localparam logic [2:0]  WAIT_CNT_1    = 3'h1;
  localparam logic [2:0]  WAIT_CNT_2    = 3'h2;
  localparam logic [2:0]  WAIT_CNT_3    = 3'h3;
  localparam logic [2:0]  WAIT_CNT_5    = 3'h5;

  typedef enum logic [1:0] {
    RDRG_SIZE_8K  = 2'h0,
    RDRG_SIZE_16K = 2'h1,
    RDRG_SIZE_32K = 2'h2,
    RDRG_SIZE_64K = 2'h3
  } rdrg_size_t;

  typedef enum logic [1:0] {
    RDRG_IDLE = 2'h0,
    RDRG_WAIT = 2'h1,
    RDRG_DONE = 2'h3,
    RDRG_HOLD = 2'h2
  } rdrg_state_t;

  typedef enum logic [1:0] {
    RDRG_TGT_NONE = 2'h0,
    RDRG_TGT_RAM  = 2'h1,
    RDRG_TGT_ROM  = 2'h2,
    RDRG_TGT_IO   = 2'h3
  } rdrg_tgt_t;

endpackage

// ### rdrg_dec_if.sv
// Decode result carried from the decoder to the cycle controller
interface rdrg_dec_if;
  rdrg_pkg::rdrg_tgt_t tgt;
  logic                deny;
  logic [2:0]          waits;
  modport dec (output tgt, output deny, output waits);
  modport ctl (input tgt, input deny, input waits);
endinterface

// ### rdrg_decode.sv
// Address decoder with permission check and wait selection
module rdrg_decode (
  input  wire logic [31:0] addr_in,
  input  wire logic        super_in,
  input  wire logic        restrict_in,
  input  wire logic        overlay_in,
  input  wire logic        rd_in,
  input  wire logic [1:0]  wait_sel_in,
  rdrg_dec_if.dec          dec
);

  logic [2:0] rom_waits;

  always_comb begin
    case (wait_sel_in)  // RULE_09
      2'h0:    rom_waits = rdrg_pkg::WAIT_CNT_1;
      2'h1:    rom_waits = rdrg_pkg::WAIT_CNT_2;
      2'h2:    rom_waits = rdrg_pkg::WAIT_CNT_3;
      default: rom_waits = rdrg_pkg::WAIT_CNT_5;
    endcase
  end

  always_comb begin
    dec.tgt   = rdrg_pkg::RDRG_TGT_NONE;
    dec.deny  = 1'b0;
    dec.waits = rdrg_pkg::RAM_WAITS;
    if (overlay_in && rd_in && addr_in <= rdrg_pkg::VEC_ADDR_1 + 32'h3) begin  // RULE_11
      dec.tgt   = rdrg_pkg::RDRG_TGT_ROM;
      dec.waits = rom_waits;
    end else if (addr_in <= rdrg_pkg::RAM_TOP) begin
      dec.tgt   = rdrg_pkg::RDRG_TGT_RAM;
      dec.waits = rdrg_pkg::RAM_WAITS;  // RULE_13
      if (restrict_in && !super_in && addr_in > rdrg_pkg::RAM_USER_TOP) begin  // RULE_02
        dec.deny = 1'b1;
      end
    end else if (addr_in >= rdrg_pkg::ROM_BASE && addr_in <= rdrg_pkg::ROM_TOP) begin  // RULE_05
      dec.tgt   = rdrg_pkg::RDRG_TGT_ROM;
      dec.waits = rom_waits;
    end else if (addr_in >= rdrg_pkg::IO_BASE && addr_in <= rdrg_pkg::IO_TOP) begin
      dec.tgt  = rdrg_pkg::RDRG_TGT_IO;
      dec.deny = restrict_in && !super_in;  // RULE_04
    end
  end

endmodule // rdrg_decode

// ### rdrg_top.sv
// ROM decode, restart overlay and RAM guard top level
module rdrg_top (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        as_n_in,
  input  wire logic        rw_in,
  input  wire logic        super_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] rom_data_in,
  input  wire logic [1:0]  rom_size_select_in,
  input  wire logic [1:0]  rom_wait_select_in,
  input  wire logic        restrict_in,
  output logic [31:0]      data_out,
  output logic             data_oe_out,
  output logic             dsack_n_out,
  output logic             berr_n_out,
  output logic [15:0]      rom_addr_out,
  output logic [3:0]       rom_ce_n_out,
  output logic             rom_oe_n_out,
  output logic             ram_sel_out,
  output logic             io_sel_out,
  output logic             overlay_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic        as_s1_reg, as_s2_reg;
  logic        rw_s1_reg, rw_s2_reg;
  logic        su_s1_reg, su_s2_reg;
  logic        rs_s1_reg, rs_s2_reg;
  logic [31:0] a_s1_reg,  a_s2_reg;
  logic [31:0] d_s1_reg,  d_s2_reg;
  logic [1:0]  sz_s1_reg, sz_s2_reg;
  logic [1:0]  ws_s1_reg, ws_s2_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      as_s1_reg <= 1'b0;
      as_s2_reg <= 1'b0;
      rw_s1_reg <= 1'b1;
      rw_s2_reg <= 1'b1;
      su_s1_reg <= 1'b0;
      su_s2_reg <= 1'b0;
      rs_s1_reg <= 1'b0;
      rs_s2_reg <= 1'b0;
      a_s1_reg  <= 32'h0;
      a_s2_reg  <= 32'h0;
      d_s1_reg  <= 32'h0;
      d_s2_reg  <= 32'h0;
      sz_s1_reg <= 2'h0;
      sz_s2_reg <= 2'h0;
      ws_s1_reg <= 2'h0;
      ws_s2_reg <= 2'h0;
    end else begin
      as_s1_reg <= !as_n_in;
      as_s2_reg <= as_s1_reg;
      rw_s1_reg <= rw_in;
      rw_s2_reg <= rw_s1_reg;
      su_s1_reg <= super_in;
      su_s2_reg <= su_s1_reg;
      rs_s1_reg <= restrict_in;
      rs_s2_reg <= rs_s1_reg;
      a_s1_reg  <= addr_in;
      a_s2_reg  <= a_s1_reg;
      d_s1_reg  <= rom_data_in;
      d_s2_reg  <= d_s1_reg;
      sz_s1_reg <= rom_size_select_in;
      sz_s2_reg <= sz_s1_reg;
      ws_s1_reg <= rom_wait_select_in;
      ws_s2_reg <= ws_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoder
  logic        overlay_reg;
  rdrg_dec_if  dec_bus ();

  rdrg_decode u_decode (
    .addr_in     (a_s2_reg),
    .super_in    (su_s2_reg),
    .restrict_in (rs_s2_reg),
    .overlay_in  (overlay_reg),
    .rd_in       (rw_s2_reg),
    .wait_sel_in (ws_s2_reg),
    .dec         (dec_bus.dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // ROM address routing with mirroring
  logic [15:0] rom_word_addr;
  logic [15:0] size_mask;

  assign rom_word_addr = a_s2_reg[17:2];  // RULE_05

  always_comb begin
    case (rdrg_pkg::rdrg_size_t'(sz_s2_reg))  // RULE_07
      rdrg_pkg::RDRG_SIZE_8K:  size_mask = 16'h1fff;  // RULE_08
      rdrg_pkg::RDRG_SIZE_16K: size_mask = 16'h3fff;
      rdrg_pkg::RDRG_SIZE_32K: size_mask = 16'h7fff;
      default:                 size_mask = 16'hffff;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle controller
  rdrg_pkg::rdrg_state_t state_reg, state_next;
  logic [2:0]            wait_reg;
  logic                  is_rom_rd;
  logic                  is_rom;

  assign is_rom    = dec_bus.tgt == rdrg_pkg::RDRG_TGT_ROM;
  assign is_rom_rd = is_rom && rw_s2_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rdrg_pkg::RDRG_IDLE: begin
        if (as_s2_reg && dec_bus.tgt != rdrg_pkg::RDRG_TGT_NONE) begin
          state_next = rdrg_pkg::RDRG_WAIT;
        end
      end
      rdrg_pkg::RDRG_WAIT: begin
        if (dec_bus.deny || wait_reg == 3'h1) begin
          state_next = rdrg_pkg::RDRG_DONE;
        end
      end
      rdrg_pkg::RDRG_DONE: state_next = rdrg_pkg::RDRG_HOLD;
      rdrg_pkg::RDRG_HOLD: begin
        if (!as_s2_reg) begin
          state_next = rdrg_pkg::RDRG_IDLE;
        end
      end
      default: state_next = rdrg_pkg::RDRG_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= rdrg_pkg::RDRG_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_reg <= 3'h0;
    end else if (state_reg == rdrg_pkg::RDRG_IDLE) begin
      wait_reg <= dec_bus.waits;  // RULE_09 RULE_13
    end else if (state_reg == rdrg_pkg::RDRG_WAIT && wait_reg != 3'h0) begin
      wait_reg <= wait_reg - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restart overlay
  logic [1:0] ovl_cnt_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ovl_cnt_reg <= 2'h0;
    end else if (overlay_reg && state_reg == rdrg_pkg::RDRG_DONE && is_rom_rd && !dec_bus.deny) begin  // RULE_15
      ovl_cnt_reg <= ovl_cnt_reg + 2'h1;
    end
  end

  // Overlay drops only once the second restart cycle has closed, so that cycle keeps its ROM target
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      overlay_reg <= 1'b1;  // RULE_11
    end else if (ovl_cnt_reg == rdrg_pkg::OVL_READS && state_next == rdrg_pkg::RDRG_IDLE) begin
      overlay_reg <= 1'b0;  // RULE_12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic active;
  assign active = state_reg != rdrg_pkg::RDRG_IDLE && !dec_bus.deny;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rom_addr_out <= 16'h0;
      rom_ce_n_out <= 4'hf;
      rom_oe_n_out <= 1'b1;
    end else begin
      rom_addr_out <= rom_word_addr & size_mask;  // RULE_07 RULE_08
      rom_ce_n_out <= (active && is_rom_rd) ? 4'h0 : 4'hf;  // RULE_15
      rom_oe_n_out <= !(active && is_rom_rd);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ram_sel_out <= 1'b0;
      io_sel_out  <= 1'b0;
    end else begin
      ram_sel_out <= active && dec_bus.tgt == rdrg_pkg::RDRG_TGT_RAM;  // RULE_01 RULE_03 RULE_14
      io_sel_out  <= active && dec_bus.tgt == rdrg_pkg::RDRG_TGT_IO;   // RULE_04 RULE_14
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dsack_n_out <= 1'b1;
      berr_n_out  <= 1'b1;
      data_out    <= 32'h0;
      data_oe_out <= 1'b0;
    end else begin
      // Answer one cycle after the last wait so the synchronised ROM word has settled
      if (state_reg == rdrg_pkg::RDRG_DONE) begin
        dsack_n_out <= dec_bus.deny;
        berr_n_out  <= !dec_bus.deny;  // RULE_14
      end else if (state_next == rdrg_pkg::RDRG_IDLE) begin
        dsack_n_out <= 1'b1;
        berr_n_out  <= 1'b1;
      end
      if (state_reg == rdrg_pkg::RDRG_DONE && is_rom_rd && !dec_bus.deny) begin
        data_out    <= {d_s2_reg[31:24], d_s2_reg[23:16], d_s2_reg[15:8], d_s2_reg[7:0]};  // RULE_06
        data_oe_out <= 1'b1;
      end else if (state_next == rdrg_pkg::RDRG_IDLE) begin
        data_oe_out <= 1'b0;
      end
    end
  end

  assign overlay_out = overlay_reg;

endmodule // rdrg_top

// ### rdrg_checker.sv
// Port checks for the ROM decode and RAM guard block
module rdrg_checker (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        super_in,
  input wire logic        restrict_in,
  input wire logic [31:0] addr_in,
  input wire logic [1:0]  rom_size_select_in,
  input wire logic [31:0] data_out,
  input wire logic        data_oe_out,
  input wire logic        dsack_n_out,
  input wire logic        berr_n_out,
  input wire logic [15:0] rom_addr_out,
  input wire logic [3:0]  rom_ce_n_out,
  input wire logic        rom_oe_n_out,
  input wire logic        ram_sel_out,
  input wire logic        io_sel_out,
  input wire logic        overlay_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////
  AST_CE_ALL: assert property (rom_ce_n_out inside {4'h0, 4'hf})
    else $error("partial chip enable");
  AST_OE_CE: assert property (!rom_oe_n_out |-> rom_ce_n_out == 4'h0)
    else $error("output enable without chip enable");
  AST_BERR_QUIET: assert property (!berr_n_out |-> !ram_sel_out && !io_sel_out && &rom_ce_n_out && dsack_n_out)
    else $error("refused cycle reached a device");
  AST_DATA_STANDS: assert property (data_oe_out && $past(data_oe_out) |-> $stable(data_out))
    else $error("read data moved while driven");
  AST_OVL_OFF: assert property (!overlay_out |=> !overlay_out)
    else $error("overlay came back");
  AST_USER_RAM: assert property (ram_sel_out && restrict_in && !super_in |-> addr_in <= rdrg_pkg::RAM_USER_TOP)
    else $error("user ram above limit");
  AST_IO_SUPER: assert property (io_sel_out && restrict_in |-> super_in)
    else $error("user io cycle allowed");
  AST_RAM_RANGE: assert property (ram_sel_out |-> addr_in <= rdrg_pkg::RAM_TOP)
    else $error("ram select outside ram");
  AST_SIZE_MASK: assert property (!rom_oe_n_out |-> (rom_addr_out >> (rom_size_select_in + 5'd13)) == 16'h0)
    else $error("rom address above device size");
  cover property (!berr_n_out);
  cover property ($fell(overlay_out));
  cover property (io_sel_out && restrict_in);
endmodule // rdrg_checker

bind rdrg_top rdrg_checker rdrg_checker_inst (.clk_sys_in, .rst_n_in, .super_in, .restrict_in, .addr_in,
  .rom_size_select_in, .data_out, .data_oe_out, .dsack_n_out, .berr_n_out, .rom_addr_out, .rom_ce_n_out,
  .rom_oe_n_out, .ram_sel_out, .io_sel_out, .overlay_out);

// ### rdrg_rom_model.sv
// Four byte-wide ROM sockets with a slow access time
module rdrg_rom_model #(parameter int ACC = 2) (
  input  wire logic        clk_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [3:0]  ce_n_in,
  input  wire logic        oe_n_in,
  output logic      [31:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  int tick = 0;
  always @(posedge clk_in) begin
    tick <= tick + 1;
    cnt <= oe_n_in ? 0 : cnt + 1;
  end
  // Valid data only after the access time, churn otherwise
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      data_out[31 - 8 * s -: 8] = (!ce_n_in[s] && !oe_n_in && cnt >= ACC) ?
        (addr_in[7:0] ^ addr_in[15:8] ^ 8'(s * 64)) : (8'(tick) ^ 8'h5a);
    end
  end
endmodule // rdrg_rom_model

// ### tb_rom_decode_and_ram_guard.sv
// Self-checking bench for the ROM decode and RAM guard block
module tb_rom_decode_and_ram_guard;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, as_n_in = 1'b1, rw_in = 1'b1, super_in = 1'b1;
  logic        restrict_in = 1'b0, data_oe_out, dsack_n_out, berr_n_out, rom_oe_n_out, ram_sel_out;
  logic        io_sel_out, overlay_out, ce_seen, ram_s, io_s, bad, doe;
  logic [31:0] addr_in = 32'h0, rom_data_in, data_out, dat;
  logic [1:0]  rom_size_select_in = 2'h3, rom_wait_select_in = 2'h3;
  logic [15:0] rom_addr_out;
  logic [3:0]  rom_ce_n_out;
  int          failures = 0, comparisons = 0, lat, lt[4];
  rdrg_top rdrg_top_inst (.clk_sys_in, .rst_n_in, .as_n_in, .rw_in, .super_in, .addr_in, .rom_data_in,
    .rom_size_select_in, .rom_wait_select_in, .restrict_in, .data_out, .data_oe_out, .dsack_n_out,
    .berr_n_out, .rom_addr_out, .rom_ce_n_out, .rom_oe_n_out, .ram_sel_out, .io_sel_out, .overlay_out);
  rdrg_rom_model #(.ACC(2)) rdrg_rom_model_inst (.clk_in(clk_sys_in), .addr_in(rom_addr_out),
    .ce_n_in(rom_ce_n_out), .oe_n_in(rom_oe_n_out), .data_out(rom_data_in));
  initial forever #25 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] expw(input logic [15:0] w);
    logic [7:0] b;
    b = w[7:0] ^ w[15:8];
    return {b, b ^ 8'h40, b ^ 8'h80, b ^ 8'hc0};
  endfunction
  task automatic final_report;
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One strobed cycle, held until answered, then released
  task automatic cyc(input logic [31:0] a, input logic r, input logic s);
    int n;
    @(posedge clk_sys_in);
    addr_in <= a;
    rw_in <= r;
    super_in <= s;
    as_n_in <= 1'b0;
    n = 0;
    ce_seen = 1'b0;
    do begin
      @(negedge clk_sys_in);
      n++;
      ce_seen = ce_seen | (rom_ce_n_out != 4'hf);
    end while (dsack_n_out && berr_n_out && n < 40);
    lat = n;
    dat = data_out;
    ram_s = ram_sel_out;
    io_s = io_sel_out;
    bad = !berr_n_out;
    doe = data_oe_out;
    if (dsack_n_out && berr_n_out) begin
      failures++;
      final_report;
    end
    @(posedge clk_sys_in) as_n_in <= 1'b1;
    n = 0;
    while (!(dsack_n_out && berr_n_out) && n < 20) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (!(dsack_n_out && berr_n_out)) begin
      failures++;
      final_report;
    end
    repeat (2) @(posedge clk_sys_in);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_overlay;
    chk(32'(overlay_out), 32'h1);
    cyc(32'h0, 1'b1, 1'b1);
    chk(dat, expw(16'h0));
    cyc(32'h4, 1'b1, 1'b1);
    chk(dat, expw(16'h1));
    chk(32'(overlay_out), 32'h0);
    cyc(32'h0, 1'b0, 1'b1);
    chk(32'({ram_s, ce_seen}), 32'h2);
  endtask
  task automatic t_sizes;
    logic [31:0] a;
    logic [15:0] m;
    for (int z = 0; z < 4; z++) begin
      @(posedge clk_sys_in) rom_size_select_in <= 2'(z);
      m = (16'h2000 << z) - 16'h1;
      a = (z == 3) ? 32'h0083_fffc : 32'h0080_0104 + (32'h8000 << z);
      cyc(a, 1'b1, 1'b1);
      chk(dat, expw(a[17:2] & m));
      chk(32'(doe), 32'h1);
    end
    cyc(32'h0080_0000, 1'b0, 1'b1);
    chk(32'({ce_seen, bad, doe}), 32'h0);
  endtask
  task automatic t_waits;
    for (int w = 0; w < 4; w++) begin
      @(posedge clk_sys_in) rom_wait_select_in <= 2'(w);
      cyc(32'h0080_0000, 1'b1, 1'b1);
      lt[w] = lat;
    end
    cyc(32'h0000_0100, 1'b1, 1'b1);
    chk(32'(lat), 32'(lt[0]));
    chk(32'(lt[1] - lt[0]), 32'h1);
    chk(32'(lt[2] - lt[0]), 32'h2);
    chk(32'(lt[3] - lt[0]), 32'h4);
  endtask
  task automatic t_guard;
    logic [31:0] ga[7] = '{32'h001f_fffc, 32'h0007_fffc, 32'h0008_0000, 32'h001f_fffc,
                           32'h00ff_8000, 32'h00ff_8000, 32'h00ff_8000};
    logic [4:0]  gf[7] = '{5'h04, 5'h14, 5'h11, 5'h1c, 5'h11, 5'h1a, 5'h02};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys_in) restrict_in <= gf[i][4];
      cyc(ga[i], 1'b1, gf[i][3]);
      chk(32'({ram_s, io_s, bad}), 32'(gf[i][2:0]));
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_overlay;
    t_sizes;
    t_waits;
    t_guard;
    final_report;
  end
endmodule // tb_rom_decode_and_ram_guard
